// [shared/eal_pkg.sv]
package eal_pkg;

    // physical address field that picks the area
    localparam int AREA_HI = 28;
    localparam int AREA_LO = 26;

    // area codes on address bits 28..26
    localparam logic [2:0] AREA0 = 3'h0;
    localparam logic [2:0] AREA1 = 3'h1;
    localparam logic [2:0] AREA2 = 3'h2;
    localparam logic [2:0] AREA3 = 3'h3;
    localparam logic [2:0] AREA4 = 3'h4;

    // width / access size codes (00 is treated as longword)
    localparam logic [1:0] SZ_BYTE = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;
    localparam logic [1:0] SZ_LONG = 2'h3;

    // external address width and sdram row split
    localparam int EXT_AW     = 26;
    localparam int SD_ROW_LSB = 13;

    // burst pitch is waits + 2, capped at ten clocks
    localparam logic [3:0] BURST_WAIT_MAX = 4'h8;

    // reset values of the pins: all strobes idle high
    localparam logic [3:0] PINS_IDLE = 4'hf;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_T1   = 3'h1,
        ST_TW   = 3'h2,
        ST_T2   = 3'h3,
        ST_ROW  = 3'h4,
        ST_COL  = 3'h5,
        ST_CAP  = 3'h6
    } eal_state_type;

    // three-bit wait field to 0..10 wait cycles
    function automatic logic [3:0] long_wait(input logic [2:0] f);
        case (f)
            3'h0:    long_wait = 4'h0;
            3'h1:    long_wait = 4'h1;
            3'h2:    long_wait = 4'h2;
            3'h3:    long_wait = 4'h3;
            3'h4:    long_wait = 4'h4;
            3'h5:    long_wait = 4'h6;
            3'h6:    long_wait = 4'h8;
            default: long_wait = 4'ha;
        endcase
    endfunction

    // size code to byte count
    function automatic logic [2:0] size_bytes(input logic [1:0] c);
        case (c)
            SZ_BYTE: size_bytes = 3'h1;
            SZ_WORD: size_bytes = 3'h2;
            default: size_bytes = 3'h4;
        endcase
    endfunction

endpackage

// [src/eal_lane_steer.sv]
`timescale 1ns/100ps
// little-endian lane steering for one beat of a split access
module eal_lane_steer (
    input  wire logic [1:0]  width_i,
    input  wire logic [1:0]  size_i,
    input  wire logic [1:0]  addr_i,
    input  wire logic [1:0]  beat_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic [31:0] ext_data_i,
    input  wire logic [31:0] rdata_i,
    output logic      [2:0]  beats_o,
    output logic      [1:0]  sub_off_o,
    output logic      [3:0]  strobe_o,
    output logic      [31:0] lane_data_o,
    output logic      [31:0] rdata_o
);
    logic [2:0]  wb;
    logic [2:0]  sb;
    logic [2:0]  bpb;
    logic [3:0]  bmask;
    logic [1:0]  fb;
    logic [1:0]  lane;
    logic [31:0] m32;
    logic [31:0] picked;

    // value byte fb of the beat lands on lane (addr + fb) mod width
    always_comb begin
        wb     = eal_pkg::size_bytes(width_i);
        sb     = eal_pkg::size_bytes(size_i);
        bpb    = (sb < wb) ? sb : wb;
        case (bpb)
            3'h1:    bmask = 4'h1;
            3'h2:    bmask = 4'h3;
            default: bmask = 4'hf;
        endcase
        fb     = 2'(beat_i * bpb[1:0]); // lowest byte first [R02] [R03]
        sub_off_o = addr_i + fb;
        lane   = sub_off_o & 2'(wb - 3'h1); // narrow ports use low lanes [R01]
        if (sb == bpb)
            beats_o = 3'h1;
        else if (sb == 3'h4 && wb == 3'h1)
            beats_o = 3'h4; // four byte beats [R03]
        else
            beats_o = 3'h2; // two halves [R02]
        strobe_o = 4'(bmask << lane); // only used lanes [R01] [R19]
        m32 = {{8{bmask[3]}}, {8{bmask[2]}}, {8{bmask[1]}}, {8{bmask[0]}}};
        lane_data_o = (wdata_i >> {fb, 3'h0}) << {lane, 3'h0};
        picked  = (ext_data_i >> {lane, 3'h0}) & m32;
        rdata_o = (rdata_i & ~(m32 << {fb, 3'h0})) | (picked << {fb, 3'h0});
    end

endmodule

// [src/eal_area_ctrl.sv]
`timescale 1ns/100ps
// Overview of operation
// R01: 16-bit port: even bytes lane 0, odd bytes lane 1; words use both.
// R02: longword on 16-bit port: offset 0 bits 15-0, then offset 2 bits 31-16.
// R03: 8-bit port: all bytes on lane 0, ascending, least significant first.
// R04: address code 000 selects area 0 with its select, read and write strobes.
// R05: address bits 31 to 29 are ignored, so areas repeat as shadows.
// R06: area 0 width comes from the two mode pins.
// R07: area 0 inserts 0 to 10 waits from its three-bit wait field.
// R08: area 0 burst beats have a pitch of 2 to 10 clocks.
// R09: code 001 is the peripheral area; no external cycle is run.
// R10: code 010 asserts the area 2 select; width from its size field.
// R11: area 2 ordinary memory uses read/write strobes and 0 to 3 waits.
// R12: the wait pin extends ordinary cycles only, never sdram ones.
// R13: area 2 sdram drives row, column, read/write and byte masks, muxed.
// R14: code 011 asserts the area 3 select; width from its size field.
// R15: area 3 ordinary memory uses read/write strobes and 0 to 3 waits.
// R16: area 3 sdram is driven like area 2 sdram.
// R17: code 100 selects area 4.
// R18: area 4 asserts its select and strobes, size field, 0 to 10 waits.
// R19: unselected selects and unused lane strobes stay high.
module eal_area_ctrl (
    input  wire logic        sys_clk_i,
    input  wire logic        nrst_i,
    input  wire logic        req_i,
    input  wire logic [31:0] req_addr_i,
    input  wire logic [1:0]  req_size_i,
    input  wire logic        req_write_i,
    input  wire logic [31:0] req_wdata_i,
    input  wire logic        width_mode_pin_a_i,
    input  wire logic        width_mode_pin_b_i,
    input  wire logic [2:0]  area0_wait_field_i,
    input  wire logic        area0_burst_i,
    input  wire logic        area2_size_hi_i,
    input  wire logic        area2_size_lo_i,
    input  wire logic        area2_wait_hi_i,
    input  wire logic        area2_wait_lo_i,
    input  wire logic        area2_sdram_i,
    input  wire logic        area3_size_hi_i,
    input  wire logic        area3_size_lo_i,
    input  wire logic        area3_wait_hi_i,
    input  wire logic        area3_wait_lo_i,
    input  wire logic        area3_sdram_i,
    input  wire logic [1:0]  area4_size_i,
    input  wire logic [2:0]  area4_wait_i,
    input  wire logic        ext_wait_n_i,
    input  wire logic [31:0] ext_data_i,
    output logic             busy_o,
    output logic             done_o,
    output logic             decline_o,
    output logic [31:0]      rdata_o,
    output logic [25:0]      ext_addr_o,
    output logic [31:0]      ext_data_o,
    output logic             ext_data_oe_n_o,
    output logic             area0_select_n_o,
    output logic             area2_select_n_o,
    output logic             area3_select_n_o,
    output logic             area4_select_n_o,
    output logic             read_strobe_n_o,
    output logic             lane0_write_strobe_n_o,
    output logic             lane1_write_strobe_n_o,
    output logic             lane2_write_strobe_n_o,
    output logic             lane3_write_strobe_n_o,
    output logic             row_strobe_upper_n_o,
    output logic             row_strobe_lower_n_o,
    output logic             column_strobe_upper_n_o,
    output logic             column_strobe_lower_n_o,
    output logic             sdram_rd_wr_o,
    output logic             lane0_byte_mask_o,
    output logic             lower_mid_byte_mask_o,
    output logic             upper_mid_byte_mask_o,
    output logic             top_byte_mask_o
);
    eal_pkg::eal_state_type state_q, state_d;
    logic [31:0] addr_q, addr_d, wdata_q, wdata_d, acc_q, acc_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0]  size_q, size_d, width_q, width_d, beat_q, beat_d;
    logic [2:0]  area_q, area_d;
    logic [3:0]  waits_q, waits_d, cnt_q, cnt_d;
    logic        write_q, write_d, sdram_q, sdram_d, burst_q, burst_d;
    logic        done_q, done_d, decline_q, decline_d;
    logic [2:0]  area_in;
    logic [2:0]  beats_q;
    logic [1:0]  sub_d, sub_unused;
    logic [3:0]  strobe_d, strobe_unused;
    logic [31:0] lane_d, lane_unused, merged_q, merged_unused;
    logic [2:0]  beats_unused;

    // pin registers; each pin output is one of these flops
    logic        busy_q, busy_d, oe_n_q, oe_n_d, rd_n_q, rd_n_d;
    logic        row_n_q, row_n_d, col_n_q, col_n_d, rw_q, rw_d;
    logic [3:0]  cs_n_q, cs_n_d, we_n_q, we_n_d, mask_q, mask_d;
    logic [25:0] xa_q, xa_d;
    logic [31:0] xd_q, xd_d;

    // shadows fold away: only bits 28..26 take part [R05]
    assign area_in = req_addr_i[eal_pkg::AREA_HI:eal_pkg::AREA_LO];

    // steering for the beat the pins will show next
    eal_lane_steer u_steer_next (
        .width_i     (width_d),
        .size_i      (size_d),
        .addr_i      (addr_d[1:0]),
        .beat_i      (beat_d),
        .wdata_i     (wdata_d),
        .ext_data_i  (ext_data_i),
        .rdata_i     (acc_q),
        .beats_o     (beats_unused),
        .sub_off_o   (sub_d),
        .strobe_o    (strobe_d),
        .lane_data_o (lane_d),
        .rdata_o     (merged_unused)
    );

    // steering for the beat on the pins now, used to gather read bytes
    eal_lane_steer u_steer_now (
        .width_i     (width_q),
        .size_i      (size_q),
        .addr_i      (addr_q[1:0]),
        .beat_i      (beat_q),
        .wdata_i     (wdata_q),
        .ext_data_i  (ext_data_i),
        .rdata_i     (acc_q),
        .beats_o     (beats_q),
        .sub_off_o   (sub_unused),
        .strobe_o    (strobe_unused),
        .lane_data_o (lane_unused),
        .rdata_o     (merged_q)
    );

    // request capture, area decode and the beat sequencer
    always_comb begin
        state_d   = state_q;
        addr_d    = addr_q;
        wdata_d   = wdata_q;
        size_d    = size_q;
        write_d   = write_q;
        width_d   = width_q;
        waits_d   = waits_q;
        sdram_d   = sdram_q;
        burst_d   = burst_q;
        area_d    = area_q;
        beat_d    = beat_q;
        cnt_d     = cnt_q;
        acc_d     = acc_q;
        rdata_d   = rdata_q;
        done_d    = 1'b0;
        decline_d = 1'b0;
        case (state_q)
            eal_pkg::ST_IDLE: begin
                if (req_i) begin
                    addr_d  = req_addr_i;
                    wdata_d = req_wdata_i;
                    size_d  = req_size_i;
                    write_d = req_write_i;
                    area_d  = area_in;
                    beat_d  = 2'h0;
                    acc_d   = 32'h0;
                    sdram_d = 1'b0;
                    burst_d = 1'b0;
                    case (area_in)
                        eal_pkg::AREA0: begin
                            // width strapped by the mode pins [R04] [R06]
                            width_d = {width_mode_pin_b_i, width_mode_pin_a_i};
                            waits_d = eal_pkg::long_wait(area0_wait_field_i); // [R07]
                            burst_d = area0_burst_i;
                            state_d = eal_pkg::ST_T1;
                        end
                        eal_pkg::AREA2: begin
                            width_d = {area2_size_hi_i, area2_size_lo_i}; // [R10]
                            waits_d = {2'h0, area2_wait_hi_i, area2_wait_lo_i}; // [R11]
                            sdram_d = area2_sdram_i;
                            state_d = area2_sdram_i ? eal_pkg::ST_ROW
                                                    : eal_pkg::ST_T1; // [R13]
                        end
                        eal_pkg::AREA3: begin
                            width_d = {area3_size_hi_i, area3_size_lo_i}; // [R14]
                            waits_d = {2'h0, area3_wait_hi_i, area3_wait_lo_i}; // [R15]
                            sdram_d = area3_sdram_i;
                            state_d = area3_sdram_i ? eal_pkg::ST_ROW
                                                    : eal_pkg::ST_T1; // [R16]
                        end
                        eal_pkg::AREA4: begin
                            width_d = area4_size_i; // [R17] [R18]
                            waits_d = eal_pkg::long_wait(area4_wait_i); // [R18]
                            state_d = eal_pkg::ST_T1;
                        end
                        default: begin
                            // peripheral area and areas not handled here:
                            // answer at once, selects and strobes stay idle; address and data pins still follow the request [R09]
                            done_d    = 1'b1;
                            decline_d = 1'b1;
                        end
                    endcase
                end
            end
            eal_pkg::ST_T1: begin
                if (waits_q != 4'h0) begin
                    state_d = eal_pkg::ST_TW;
                    cnt_d   = waits_q; // [R07] [R11] [R15]
                end else begin
                    state_d = eal_pkg::ST_T2;
                end
            end
            eal_pkg::ST_TW: begin
                // the wait pin is looked at only on the last Tw [R12]
                if (cnt_q > 4'h1)
                    cnt_d = cnt_q - 4'h1;
                else if (ext_wait_n_i)
                    state_d = eal_pkg::ST_T2;
            end
            eal_pkg::ST_ROW: state_d = eal_pkg::ST_COL; // [R12] [R13]
            eal_pkg::ST_COL: state_d = eal_pkg::ST_CAP;
            eal_pkg::ST_T2, eal_pkg::ST_CAP: begin
                acc_d = merged_q;
                if ({1'b0, beat_q} + 3'h1 == beats_q) begin
                    state_d = eal_pkg::ST_IDLE;
                    done_d  = 1'b1;
                    rdata_d = write_q ? rdata_q : merged_q;
                end else begin
                    beat_d = beat_q + 2'h1; // next split beat [R02] [R03]
                    if (sdram_q) begin
                        state_d = eal_pkg::ST_ROW;
                    end else if (burst_q) begin
                        // burst beats skip T1: pitch = waits + 2, capped at ten clocks [R08]
                        state_d = eal_pkg::ST_TW;
                        cnt_d = ((waits_q > eal_pkg::BURST_WAIT_MAX)
                                 ? eal_pkg::BURST_WAIT_MAX : waits_q) + 4'h1;
                    end else begin
                        state_d = eal_pkg::ST_T1;
                    end
                end
            end
            default: state_d = eal_pkg::ST_IDLE;
        endcase
    end

    logic ord_d, ext_d;

    // pin values for the cycle that state_d describes
    always_comb begin
        ord_d  = state_d == eal_pkg::ST_T1 || state_d == eal_pkg::ST_TW ||
                 state_d == eal_pkg::ST_T2;
        ext_d  = state_d != eal_pkg::ST_IDLE;
        busy_d = ext_d;
        // only the decoded area's select goes low [R04] [R19]
        cs_n_d = ~({4{ext_d}} & {area_d == eal_pkg::AREA4,
                                 area_d == eal_pkg::AREA3,
                                 area_d == eal_pkg::AREA2,
                                 area_d == eal_pkg::AREA0});
        rd_n_d = ~(ord_d && !write_d); // [R11] [R15] [R18]
        we_n_d = ~({4{ord_d && write_d}} & strobe_d); // [R01] [R19]
        oe_n_d = ~((ord_d || state_d == eal_pkg::ST_COL) && write_d);
        xd_d   = lane_d;
        row_n_d = state_d != eal_pkg::ST_ROW; // [R13] [R16]
        col_n_d = state_d != eal_pkg::ST_COL;
        rw_d    = !write_d;
        mask_d  = (state_d == eal_pkg::ST_COL) ? ~strobe_d
                                               : eal_pkg::PINS_IDLE;
        // row phase carries the high half, column phase the low half
        if (state_d == eal_pkg::ST_ROW)
            xa_d = {{eal_pkg::SD_ROW_LSB{1'b0}},
                    addr_d[eal_pkg::EXT_AW-1:eal_pkg::SD_ROW_LSB]};
        else if (state_d == eal_pkg::ST_COL)
            xa_d = {{eal_pkg::SD_ROW_LSB{1'b0}},
                    addr_d[eal_pkg::SD_ROW_LSB-1:2], sub_d};
        else
            xa_d = {addr_d[eal_pkg::EXT_AW-1:2], sub_d}; // [R02] [R03]
    end

    // all state and pins in one bank; strobes and selects reset to idle-high, address and data pins to 0
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= eal_pkg::ST_IDLE;
            addr_q  <= 32'h0;
            wdata_q <= 32'h0;
            acc_q   <= 32'h0;
            rdata_q <= 32'h0;
            size_q  <= eal_pkg::SZ_LONG;
            width_q <= eal_pkg::SZ_LONG;
            beat_q  <= 2'h0;
            area_q  <= eal_pkg::AREA0;
            waits_q <= 4'h0;
            cnt_q   <= 4'h0;
            write_q <= 1'b0;
            sdram_q <= 1'b0;
            burst_q <= 1'b0;
            done_q  <= 1'b0;
            decline_q <= 1'b0;
            busy_q  <= 1'b0;
            oe_n_q  <= 1'b1;
            rd_n_q  <= 1'b1;
            row_n_q <= 1'b1;
            col_n_q <= 1'b1;
            rw_q    <= 1'b1;
            cs_n_q  <= eal_pkg::PINS_IDLE;
            we_n_q  <= eal_pkg::PINS_IDLE;
            mask_q  <= eal_pkg::PINS_IDLE;
            xa_q    <= 26'h0;
            xd_q    <= 32'h0;
        end else begin
            state_q <= state_d;
            addr_q  <= addr_d;
            wdata_q <= wdata_d;
            acc_q   <= acc_d;
            rdata_q <= rdata_d;
            size_q  <= size_d;
            width_q <= width_d;
            beat_q  <= beat_d;
            area_q  <= area_d;
            waits_q <= waits_d;
            cnt_q   <= cnt_d;
            write_q <= write_d;
            sdram_q <= sdram_d;
            burst_q <= burst_d;
            done_q  <= done_d;
            decline_q <= decline_d;
            busy_q  <= busy_d;
            oe_n_q  <= oe_n_d;
            rd_n_q  <= rd_n_d;
            row_n_q <= row_n_d;
            col_n_q <= col_n_d;
            rw_q    <= rw_d;
            cs_n_q  <= cs_n_d;
            we_n_q  <= we_n_d;
            mask_q  <= mask_d;
            xa_q    <= xa_d;
            xd_q    <= xd_d;
        end
    end

    assign busy_o                  = busy_q;
    assign done_o                  = done_q;
    assign decline_o               = decline_q;
    assign rdata_o                 = rdata_q;
    assign ext_addr_o              = xa_q;
    assign ext_data_o              = xd_q;
    assign ext_data_oe_n_o         = oe_n_q;
    assign area0_select_n_o        = cs_n_q[0];
    assign area2_select_n_o        = cs_n_q[1];
    assign area3_select_n_o        = cs_n_q[2];
    assign area4_select_n_o        = cs_n_q[3];
    assign read_strobe_n_o         = rd_n_q;
    assign lane0_write_strobe_n_o  = we_n_q[0];
    assign lane1_write_strobe_n_o  = we_n_q[1];
    assign lane2_write_strobe_n_o  = we_n_q[2];
    assign lane3_write_strobe_n_o  = we_n_q[3];
    assign row_strobe_upper_n_o    = row_n_q; // both halves move together
    assign row_strobe_lower_n_o    = row_n_q;
    assign column_strobe_upper_n_o = col_n_q;
    assign column_strobe_lower_n_o = col_n_q;
    assign sdram_rd_wr_o           = rw_q;
    assign lane0_byte_mask_o       = mask_q[0];
    assign lower_mid_byte_mask_o   = mask_q[1];
    assign upper_mid_byte_mask_o   = mask_q[2];
    assign top_byte_mask_o         = mask_q[3];

    // checks on the pins against the sequencer
    one_select_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        $onehot0(~cs_n_q)) else $error("two selects low"); // [R19]
    area0_decode_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        state_q == eal_pkg::ST_IDLE && req_i && area_in == eal_pkg::AREA0
        |=> !area0_select_n_o ##1 !area0_select_n_o)
        else $error("area 0 select missing"); // [R04]
    periph_quiet_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        state_q == eal_pkg::ST_IDLE && req_i && area_in == eal_pkg::AREA1
        |=> done_o && decline_o && cs_n_q == eal_pkg::PINS_IDLE)
        else $error("peripheral area ran a cycle"); // [R09]
    byte_lane_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        state_q == eal_pkg::ST_T2 && width_q == eal_pkg::SZ_BYTE
        |-> we_n_q[3:1] == 3'h7) else $error("8-bit lane misuse"); // [R03]
    long16_order_a: assert property (@(posedge sys_clk_i)
        disable iff (!nrst_i)
        state_q == eal_pkg::ST_T2 && width_q == eal_pkg::SZ_WORD &&
        size_q == eal_pkg::SZ_LONG
        |-> ext_addr_o[1:0] == {beat_q[0], 1'b0})
        else $error("16-bit long beat offset"); // [R02]
    odd16_lane_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        state_q == eal_pkg::ST_T2 && write_q && addr_q[0] &&
        width_q == eal_pkg::SZ_WORD && size_q == eal_pkg::SZ_BYTE
        |-> we_n_q == 4'hd) else $error("odd byte not on lane 1"); // [R01]
    short_wait_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        state_q == eal_pkg::ST_T1 && waits_q == 4'h2
        |=> state_q == eal_pkg::ST_TW ##1 state_q == eal_pkg::ST_TW)
        else $error("two waits not held"); // [R11]
    long_wait_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        state_q == eal_pkg::ST_T1 && waits_q == 4'ha
        |=> (state_q == eal_pkg::ST_TW) [*8])
        else $error("ten waits cut short"); // [R07]
    sdram_nowait_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        state_q == eal_pkg::ST_ROW
        |=> !column_strobe_lower_n_o ##1 state_q == eal_pkg::ST_CAP)
        else $error("sdram beat stalled"); // [R12]

endmodule

// [tb/eal_mem_model.sv]
`timescale 1ns/100ps
// external memory stand-in: read bytes follow the address, writes are logged
module eal_mem_model (
    input  wire logic        sys_clk_i,
    input  wire logic        sel_n_i,
    input  wire logic        rd_n_i,
    input  wire logic [25:0] addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic [3:0]  wstb_n_i,
    input  wire logic [3:0]  stall_i,
    output logic      [31:0] rdata_o,
    output logic             wait_n_o
);
    logic [31:0] log_q [0:7];
    logic [3:0]  stb_q [0:7];
    logic [3:0]  n_q    = 4'h0;
    logic [3:0]  cnt_q  = 4'h0;
    logic [31:0] last_q = 32'h0;
    logic [25:0] addr_q = 26'h0;
    logic        wr_q   = 1'h0;
    logic [7:0]  b;

    // released bus toggles so a late sample never sees the old value
    always_comb begin
        b = addr_i[7:0];
        if (!rd_n_i) begin
            rdata_o = {b + 8'h3, b + 8'h2, b + 8'h1, b};
        end else begin
            rdata_o = ~last_q;
        end
    end
    assign wait_n_o = (cnt_q >= stall_i);

    // one log entry per beat: strobe start or a new beat address
    always_ff @(posedge sys_clk_i) begin
        cnt_q <= sel_n_i ? 4'h0 : cnt_q + 4'h1;
        last_q <= rdata_o;
        wr_q <= ~&wstb_n_i;
        addr_q <= addr_i;
        if (~&wstb_n_i && (!wr_q || addr_q != addr_i)) begin
            log_q[n_q[2:0]] <= wdata_i;
            stb_q[n_q[2:0]] <= wstb_n_i;
            n_q <= n_q + 4'h1;
        end
    end
endmodule

// [tb/tb.sv]
`timescale 1ns/100ps
// directed bench: area decode, lane steering and wait counts
module tb;
    logic        sys_clk_i = 1'h0, nrst_i = 1'h0, req_i = 1'h0;
    logic        req_write_i = 1'h0, area2_sdram_i = 1'h0;
    logic        area0_burst_i = 1'h0;
    logic        area3_sdram_i = 1'h0, ext_wait_n_i, busy_o, done_o;
    logic        decline_o, read_strobe_n_o, row_strobe_upper_n_o, rows;
    logic [31:0] req_addr_i = 32'h0, req_wdata_i = 32'h0;
    logic [31:0] ext_data_i, rdata_o, ext_data_o;
    logic [25:0] ext_addr_o;
    logic [1:0]  req_size_i = 2'h3, area4_size_i = 2'h3, md = 2'h3;
    logic [1:0]  a2s = 2'h3, a2w = 2'h0, a3s = 2'h3, a3w = 2'h0;
    logic [2:0]  area0_wait_field_i = 3'h0, area4_wait_i = 3'h0;
    logic [3:0]  sel, ws, sels, dqm, msk, stall = 4'h0;
    logic [31:0] adr [4] = '{32'h0, 32'h08000000, 32'h0c000000, 32'h10000000};
    int          bt [4] = '{12, 5, 4, 12};
    logic [3:0]  sx [4] = '{4'he, 4'hd, 4'hb, 4'h7};
    int          fail_count = 0, n_tests = 0, nb, base;

    eal_area_ctrl uut (.sys_clk_i, .nrst_i, .req_i, .req_addr_i, .req_size_i,
        .req_write_i, .req_wdata_i, .width_mode_pin_a_i(md[0]),
        .width_mode_pin_b_i(md[1]), .area0_wait_field_i, .area0_burst_i,
        .area2_size_hi_i(a2s[1]), .area2_size_lo_i(a2s[0]),
        .area2_wait_hi_i(a2w[1]), .area2_wait_lo_i(a2w[0]), .area2_sdram_i,
        .area3_size_hi_i(a3s[1]), .area3_size_lo_i(a3s[0]),
        .area3_wait_hi_i(a3w[1]), .area3_wait_lo_i(a3w[0]), .area3_sdram_i,
        .area4_size_i, .area4_wait_i, .ext_wait_n_i, .ext_data_i, .busy_o,
        .done_o, .decline_o, .rdata_o, .ext_addr_o, .ext_data_o,
        .ext_data_oe_n_o(), .area0_select_n_o(sel[0]),
        .area2_select_n_o(sel[1]), .area3_select_n_o(sel[2]),
        .area4_select_n_o(sel[3]), .read_strobe_n_o,
        .lane0_write_strobe_n_o(ws[0]), .lane1_write_strobe_n_o(ws[1]),
        .lane2_write_strobe_n_o(ws[2]), .lane3_write_strobe_n_o(ws[3]),
        .row_strobe_upper_n_o, .row_strobe_lower_n_o(),
        .column_strobe_upper_n_o(), .column_strobe_lower_n_o(),
        .sdram_rd_wr_o(), .lane0_byte_mask_o(dqm[0]),
        .lower_mid_byte_mask_o(dqm[1]), .upper_mid_byte_mask_o(dqm[2]),
        .top_byte_mask_o(dqm[3]));
    eal_mem_model mem (.sys_clk_i, .sel_n_i(&sel), .rd_n_i(read_strobe_n_o),
        .addr_i(ext_addr_o), .wdata_i(ext_data_o), .wstb_n_i(ws),
        .stall_i(stall), .rdata_o(ext_data_i), .wait_n_o(ext_wait_n_i));

    always #4 sys_clk_i = ~sys_clk_i;

    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one request; counts busy cycles and gathers selects seen meanwhile
    task automatic acc(input logic [31:0] a, input logic [1:0] sz,
                       input logic wr, input logic [31:0] wd);
        @(posedge sys_clk_i);
        #1 {req_i, req_addr_i, req_size_i, req_write_i} = {1'h1, a, sz, wr};
        req_wdata_i = wd;
        base = mem.n_q;
        @(posedge sys_clk_i);
        #1 req_i = 1'h0;
        {nb, sels, rows} = '0;
        {sels, msk} = 8'hff;
        for (int k = 0; k < 300 && done_o !== 1'h1; k++) begin
            nb += (busy_o === 1'h1);
            sels &= sel;
            msk &= dqm;
            rows |= (row_strobe_upper_n_o === 1'h0);
            @(posedge sys_clk_i);
            #1;
        end
        chk("done", 1'h1, done_o);
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // main sequence: 8-bit area 0, 16-bit area 2, wait table, sdram
    initial begin
        repeat (5) @(posedge sys_clk_i);
        #1 nrst_i = 1'h1;
        md = 2'h1;
        acc(32'h00000010, 2'h3, 1'h1, 32'h44332211);
        chk("beats", 8, nb);
        chk("sel", 4'he, sels);
        for (int i = 0; i < 4; i++) begin
            chk("byte", 8'h11 * (i + 1), mem.log_q[3'(base + i)][7:0]);
            chk("stb", 4'he, mem.stb_q[3'(base + i)]);
        end
        acc(32'he0000010, 2'h3, 1'h0, 32'h0);
        chk("rd8", 32'h13121110, rdata_o);
        a2s = 2'h2;
        acc(32'h08000020, 2'h3, 1'h1, 32'hddccbbaa);
        chk("lo", 32'hbbaa, mem.log_q[3'(base)][15:0]);
        chk("hi", 32'hddcc, mem.log_q[3'(base + 1)][15:0]);
        chk("stb", 4'hc, mem.stb_q[3'(base + 1)]);
        acc(32'h08000021, 2'h1, 1'h1, 32'h5a);
        chk("odd", 32'h5a, mem.log_q[3'(base)][15:8]);
        chk("ostb", 4'hd, mem.stb_q[3'(base)]);
        acc(32'h28000010, 2'h3, 1'h0, 32'h0);
        chk("rd16", 32'h13121110, rdata_o);
        chk("sel", 4'hd, sels);
        {md, a2s, a2w, a3w} = {2'h3, 2'h3, 2'h3, 2'h2};
        {area0_wait_field_i, area4_wait_i} = {3'h7, 3'h7};
        for (int i = 0; i < 4; i++) begin
            acc(adr[i], 2'h3, 1'h0, 32'h0);
            chk("waits", bt[i], nb);
            chk("sel", sx[i], sels);
        end
        acc(32'h04000000, 2'h3, 1'h0, 32'h0);
        chk("decl", 1'h1, decline_o);
        chk("nosel", 4'hf, sels);
        {a2w, stall} = {2'h1, 4'h3};
        acc(32'h08000000, 2'h3, 1'h0, 32'h0);
        chk("stretch", 5, nb);
        {area2_sdram_i, area3_sdram_i} = 2'h3;
        for (int i = 1; i < 3; i++) begin
            acc(adr[i], 2'h3, 1'h0, 32'h0);
            chk("sdram", 3, nb);
            chk("row", 1'h1, rows);
            chk("mask", 4'h0, msk);
        end
        {md, area0_burst_i, stall} = {2'h2, 1'h1, 4'h0};
        acc(32'h0, 2'h3, 1'h0, 32'h0);
        chk("burst", 22, nb);
        print_verdict();
    end

    initial begin
        repeat (5000) @(posedge sys_clk_i);
        fail_count++;
        print_verdict();
    end
endmodule
